// ===== sbsc_ctrl.sv
// Function
// - two-bit burst counter loads from address bits 1:0, wraps after four
// - mode input high selects interleaved order, low selects linear order
// - advance low during a burst steps the counter
// - interleaved address is start xor count
// - linear address is start plus count modulo four
// - write bursts use the same counter and order as reads
// - sleep request high tri-states data and powers down regardless of inputs
// - sleep entered within two cycles, left at the first clock after request falls
// - stored contents kept while asleep; pending access may be lost
// - deselect when primary high and controller strobe low, or primary low, depth inactive and a strobe low
// - processor strobe with all selects begins read, writes ignored
// - controller strobe alone with selects begins burst, write per qualifier
// - strobes idle and advance low continue burst at next address
// - write when global write low or byte enable low with a lane
// - output enable gates reads only; masked in writes, off when deselected
// - advance high with strobes idle suspends burst at current address
// - read data registered and driven one cycle later
// - outputs driven one more clock after a registered deselect
`timescale 1ns/100ps
`default_nettype none
module sbsc_ctrl
   import sbsc_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                rst_n_i,
   // selects and strobes
   input  wire logic                chip_enable_primary_n_i,
   input  wire logic                depth_enable_high_i,
   input  wire logic                depth_enable_low_n_i,
   input  wire logic                processor_address_strobe_n_i,
   input  wire logic                controller_address_strobe_n_i,
   input  wire logic                burst_advance_n_i,
   // write qualifiers
   input  wire logic                global_write_n_i,
   input  wire logic                byte_write_enable_n_i,
   input  wire logic [LANES-1:0]    byte_lane_select_n_i,
   // static mode, sleep and output enable
   input  wire logic                burst_mode_i,
   input  wire logic                sleep_request_i,
   input  wire logic                output_enable_n_i,
   // address and data
   input  wire logic [ADDR_W-1:0]   addr_i,
   input  wire logic [DATA_W-1:0]   data_i,
   output logic      [DATA_W-1:0]   data_o,
   output logic                     data_oe_n_o,
   // status
   output logic                     asleep_o,
   output logic [BURST_W-1:0]       burst_addr_o
);
   sbsc_sleep_t           sleep_q, sleep_d;
   logic [1:0]            scnt_q, scnt_d;
   logic [ADDR_W-1:0]     base_q, base_d;
   logic [BURST_W-1:0]    start_q, start_d;
   logic [BURST_W-1:0]    count_q, count_d;
   logic                  active_q, active_d;
   logic                  rd_q, rd_d;
   logic                  drive_q, drive_d;
   logic                  drive2_q, drive2_d;
   logic [DATA_W-1:0]     data_q, data_d;

   logic                  selected;
   logic                  deselect;
   logic                  begin_rd;
   logic                  begin_acc;
   logic                  cont;
   logic                  suspend;
   logic                  wr_qual;
   logic                  awake;
   logic                  mem_we;
   logic                  mem_re;
   logic [ADDR_W-1:0]     mem_addr;
   logic [BURST_W-1:0]    cur_addr;
   logic [DATA_W-1:0]     rdata;

   assign wr_qual = !global_write_n_i
                    || (!byte_write_enable_n_i && !(&byte_lane_select_n_i));
   assign selected = !chip_enable_primary_n_i && depth_enable_high_i
                     && !depth_enable_low_n_i;
   assign awake = (sleep_q == SBSC_AWAKE) && !sleep_request_i;

   assign deselect = awake && (
      (chip_enable_primary_n_i && !controller_address_strobe_n_i)
      || (!chip_enable_primary_n_i && !(depth_enable_high_i && !depth_enable_low_n_i)
          && (!processor_address_strobe_n_i || !controller_address_strobe_n_i)));
   assign begin_rd = awake && selected && !processor_address_strobe_n_i;
   assign begin_acc = begin_rd || (awake && selected && processor_address_strobe_n_i
                                   && !controller_address_strobe_n_i);
   assign cont = awake && active_q && !burst_advance_n_i && controller_address_strobe_n_i
                 && (processor_address_strobe_n_i || chip_enable_primary_n_i);
   assign suspend = awake && active_q && burst_advance_n_i
                    && controller_address_strobe_n_i
                    && (processor_address_strobe_n_i || chip_enable_primary_n_i);

   assign cur_addr = sbsc_burst_addr(start_q, count_q, burst_mode_i);

   always_comb begin
      base_d   = base_q;
      start_d  = start_q;
      count_d  = count_q;
      active_d = active_q;
      rd_d     = 1'b0;
      mem_we   = 1'b0;
      mem_re   = 1'b0;
      mem_addr = {base_q[ADDR_W-1:BURST_W], cur_addr};
      if (begin_acc) begin
         // counter loads from address low bits
         base_d   = addr_i;
         start_d  = addr_i[BURST_W-1:0];
         count_d  = 2'h0;
         active_d = 1'b1;
         mem_addr = addr_i;
         mem_we   = !begin_rd && wr_qual;
         mem_re   = begin_rd || !wr_qual;
         rd_d     = mem_re;
      end else if (cont) begin
         count_d  = count_q + 2'h1;
         mem_addr = {base_q[ADDR_W-1:BURST_W],
                     sbsc_burst_addr(start_q, count_d, burst_mode_i)};
         mem_we   = wr_qual;
         mem_re   = !wr_qual;
         rd_d     = mem_re;
      end else if (suspend) begin
         mem_we   = wr_qual;
         mem_re   = !wr_qual;
         rd_d     = mem_re;
      end else if (deselect || !awake) begin
         active_d = 1'b0;
      end
   end

   // output pipeline: drive after read, hold one clock past deselect
   always_comb begin
      drive_d  = rd_q;
      drive2_d = drive_q && !rd_q && !deselect;
      data_d   = rdata;
      if (!awake) begin
         drive_d  = 1'b0;
         drive2_d = 1'b0;
      end
   end

   always_comb begin
      sleep_d = sleep_q;
      scnt_d  = scnt_q;
      case (sleep_q)
         SBSC_AWAKE: begin
            if (sleep_request_i) begin
               sleep_d = SBSC_ENTERING;
               scnt_d  = 2'(SLEEP_ENTRY_CYC - 1);
            end else if (scnt_q != SLEEP_CNT_ZERO) begin
               scnt_d = scnt_q - 2'h1;
            end
         end
         SBSC_ENTERING: begin
            if (scnt_q <= 2'h1) begin
               sleep_d = SBSC_ASLEEP;
            end else begin
               scnt_d = scnt_q - 2'h1;
            end
         end
         SBSC_ASLEEP: begin
            if (!sleep_request_i) begin
               sleep_d = SBSC_AWAKE;
               scnt_d  = 2'(SLEEP_RECOVERY_CYC);
            end
         end
         default: begin
            sleep_d = SBSC_AWAKE;
            scnt_d  = SLEEP_CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sleep_q  <= SBSC_AWAKE;
         scnt_q   <= SLEEP_CNT_ZERO;
         base_q   <= '0;
         start_q  <= '0;
         count_q  <= '0;
         active_q <= 1'b0;
         rd_q     <= 1'b0;
         drive_q  <= 1'b0;
         drive2_q <= 1'b0;
         data_q   <= '0;
      end else begin
         sleep_q  <= sleep_d;
         scnt_q   <= scnt_d;
         base_q   <= base_d;
         start_q  <= start_d;
         count_q  <= count_d;
         active_q <= active_d;
         rd_q     <= rd_d;
         drive_q  <= drive_d;
         drive2_q <= drive2_d;
         data_q   <= data_d;
      end
   end

   // array keeps contents; accesses gated off while not awake
   sbsc_mem u_mem (
      .ref_clk_i (ref_clk_i),
      .we_i      (mem_we),
      .lane_we_i (global_write_n_i ? ~byte_lane_select_n_i : {LANES{1'b1}}),
      .addr_i    (mem_addr),
      .wdata_i   (data_i),
      .re_i      (mem_re),
      .rdata_o   (rdata)
   );

   // output enable gates reads only, sleep tri-states at once
   assign data_oe_n_o = !((drive_q || drive2_q) && !output_enable_n_i
                          && !sleep_request_i && !mem_we);
   // output register lines data up with the drive pipeline
   assign data_o       = data_q;
   assign asleep_o     = (sleep_q == SBSC_ASLEEP);
   assign burst_addr_o = cur_addr;
endmodule
`default_nettype wire

// ===== sbsc_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sbsc_ctrl_checker
   import sbsc_pkg::*;
(
   // clock and reset
   input wire logic               ref_clk_i,
   input wire logic               rst_n_i,
   // bus inputs
   input wire logic               chip_enable_primary_n_i,
   input wire logic               depth_enable_high_i,
   input wire logic               depth_enable_low_n_i,
   input wire logic               processor_address_strobe_n_i,
   input wire logic               controller_address_strobe_n_i,
   input wire logic               burst_advance_n_i,
   input wire logic               burst_mode_i,
   input wire logic               sleep_request_i,
   input wire logic               output_enable_n_i,
   input wire logic [ADDR_W-1:0]  addr_i,
   // outputs
   input wire logic               data_oe_n_o,
   input wire logic               asleep_o,
   input wire logic [BURST_W-1:0] burst_addr_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic       sel  = !chip_enable_primary_n_i && depth_enable_high_i && !depth_enable_low_n_i;
   wire logic       idle = processor_address_strobe_n_i && controller_address_strobe_n_i;
   wire logic       awake = !sleep_request_i && !asleep_o;
   wire logic       desel = (chip_enable_primary_n_i && !controller_address_strobe_n_i)
                            || (!chip_enable_primary_n_i && !sel && !idle);
   wire logic [1:0] low_a = addr_i[1:0];

   AST_SLEEP_OFF: assert property (sleep_request_i |-> data_oe_n_o)
      else $error("data driven while sleep requested");
   AST_SLEEP_IN: assert property ($rose(sleep_request_i) |-> ##[0:2] asleep_o)
      else $error("sleep state not entered in time");
   AST_SLEEP_OUT: assert property ($fell(sleep_request_i) |-> ##[0:2] !asleep_o)
      else $error("sleep state not left in time");
   AST_OE_GATE: assert property (output_enable_n_i |-> data_oe_n_o)
      else $error("data driven with output enable off");
   AST_DESEL_OFF: assert property (desel ##1 (chip_enable_primary_n_i || idle) |=> data_oe_n_o)
      else $error("data still driven after deselect");
   AST_BURST_LOAD: assert property (sel && !idle && awake |=> burst_addr_o == $past(low_a))
      else $error("burst start not loaded from address");
   AST_LINEAR_STEP: assert property (!burst_mode_i && idle && !burst_advance_n_i && awake
      ##1 !burst_mode_i |-> burst_addr_o == $past(burst_addr_o) + 2'h1)
      else $error("linear step wrong");
   AST_SUSPEND: assert property (idle && burst_advance_n_i && !sleep_request_i |=> $stable(burst_addr_o))
      else $error("suspended burst address moved");
endmodule
bind sbsc_ctrl sbsc_ctrl_checker u_chk (.*);
`default_nettype wire

// ===== sbsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbsc_host_model
   import sbsc_pkg::*;
(
   // clock
   input  wire logic              clk_i,
   // selects, strobes, sleep
   output logic                   pe_n_o,
   output logic                   deh_o,
   output logic                   del_n_o,
   output logic                   ps_n_o,
   output logic                   cs_n_o,
   output logic                   step_n_o,
   output logic                   slp_o,
   // write qualifiers and output enable
   output logic                   gwr_n_o,
   output logic                   bwen_o,
   output logic [LANES-1:0]       lane_n_o,
   output logic                   oe_n_o,
   // address and data
   output logic [ADDR_W-1:0]      addr_o,
   output logic [DATA_W-1:0]      data_o
);
   assign deh_o   = 1'b1;
   assign del_n_o = 1'b0;
   initial begin
      {pe_n_o, ps_n_o, cs_n_o, step_n_o, slp_o} = 5'b11110;
      {gwr_n_o, bwen_o, lane_n_o} = 6'h3f;
      oe_n_o = 1'b1;
      addr_o = '0;
      data_o = '0;
   end
   // one bus cycle: drive after the falling edge, return after the rising edge
   task automatic cyc(input logic [4:0] c, input logic [5:0] w,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk_i);
      {pe_n_o, ps_n_o, cs_n_o, step_n_o, slp_o} = c;
      {gwr_n_o, bwen_o, lane_n_o} = w;
      oe_n_o = !(w[5] && (w[4] || &w[3:0]));
      addr_o = a;
      // released data lines toggle rather than hold
      data_o = oe_n_o ? d : ~data_o;
      @(posedge clk_i);
      #1;
   endtask
   task automatic sleep_on;
      cyc(5'b11010, 6'h3f, '0, '0);
      cyc(5'b11111, 6'h3f, '0, '0);
   endtask
   task automatic sleep_off;
      repeat (2) cyc(5'b11110, 6'h3f, '0, '0);
   endtask
endmodule
`default_nettype wire

// ===== sbsc_mem.sv
`timescale 1ns/100ps
`default_nettype none
module sbsc_mem
   import sbsc_pkg::*;
(
   // clock
   input  wire logic                ref_clk_i,
   // write port
   input  wire logic                we_i,
   input  wire logic [LANES-1:0]    lane_we_i,
   input  wire logic [ADDR_W-1:0]   addr_i,
   input  wire logic [DATA_W-1:0]   wdata_i,
   // read port
   input  wire logic                re_i,
   output logic      [DATA_W-1:0]   rdata_o
);
   localparam int unsigned LANE_W = DATA_W / LANES;

   logic [DATA_W-1:0] mem_q [DEPTH];
   logic [DATA_W-1:0] rdata_q;

   // one writing process, so the array has a single driver
   always_ff @(posedge ref_clk_i) begin
      if (we_i) begin
         for (int l = 0; l < LANES; l++) begin
            if (lane_we_i[l]) begin
               mem_q[addr_i][l*LANE_W +: LANE_W] <= wdata_i[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (re_i) begin
         rdata_q <= mem_q[addr_i];
      end
   end

   assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// ===== sbsc_pkg.sv
package sbsc_pkg;
   // burst address width and memory geometry
   localparam int unsigned BURST_W     = 2;
   localparam int unsigned ADDR_W      = 10;
   localparam int unsigned DATA_W      = 36;
   localparam int unsigned LANES       = 4;
   localparam int unsigned DEPTH       = 1024;
   // sleep entry and recovery, given in ns and converted to clock cycles
   localparam int unsigned CLK_PERIOD_NS      = 25;
   localparam int unsigned SLEEP_ENTRY_NS     = 50;
   localparam int unsigned SLEEP_RECOVERY_NS  = 50;
   localparam int unsigned SLEEP_ENTRY_CYC    =
      (SLEEP_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1 : SLEEP_ENTRY_NS / CLK_PERIOD_NS;
   localparam int unsigned SLEEP_RECOVERY_CYC =
      (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;

   typedef enum logic [2:0] {
      SBSC_AWAKE    = 3'h1,
      SBSC_ENTERING = 3'h2,
      SBSC_ASLEEP   = 3'h4
   } sbsc_sleep_t;

   // next burst address for the selected order
   function automatic logic [BURST_W-1:0] sbsc_burst_addr(
      input logic [BURST_W-1:0] start,
      input logic [BURST_W-1:0] count,
      input logic               interleaved);
      if (interleaved) begin
         sbsc_burst_addr = start ^ count;
      end else begin
         sbsc_burst_addr = start + count;
      end
   endfunction
endpackage

// ===== sync_burst_sram_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sync_burst_sram_control_tb;
   import sbsc_pkg::*;
   localparam logic [4:0] BEGIN_P = 5'b00110;
   localparam logic [4:0] BEGIN_C = 5'b01010;
   localparam logic [4:0] CONT    = 5'b01100;
   localparam logic [4:0] DESEL   = 5'b11010;
   localparam logic [5:0] RD      = 6'h3f;
   localparam logic [5:0] WR      = 6'h1f;
   localparam logic [5:0] BYTE0   = 6'h2e;
   logic               ref_clk_i, rst_n_i, mode, pe_n, deh, del_n, ps_n, cs_n, step_n;
   logic               slp, gwr_n, bwen, oe_n, data_oe_n_o, asleep_o;
   logic [LANES-1:0]   lane_n;
   logic [ADDR_W-1:0]  addr;
   logic [DATA_W-1:0]  wdata, data_o;
   logic [BURST_W-1:0] burst_addr_o;
   int                 n_mismatch = 0;
   int                 samples_checked = 0;

   sbsc_host_model host (.clk_i(ref_clk_i), .pe_n_o(pe_n), .deh_o(deh), .del_n_o(del_n),
      .ps_n_o(ps_n), .cs_n_o(cs_n), .step_n_o(step_n), .slp_o(slp), .gwr_n_o(gwr_n),
      .bwen_o(bwen), .lane_n_o(lane_n), .oe_n_o(oe_n), .addr_o(addr), .data_o(wdata));
   sbsc_ctrl dut (.ref_clk_i, .rst_n_i, .chip_enable_primary_n_i(pe_n),
      .depth_enable_high_i(deh), .depth_enable_low_n_i(del_n),
      .processor_address_strobe_n_i(ps_n), .controller_address_strobe_n_i(cs_n),
      .burst_advance_n_i(step_n), .global_write_n_i(gwr_n), .byte_write_enable_n_i(bwen),
      .byte_lane_select_n_i(lane_n), .burst_mode_i(mode), .sleep_request_i(slp),
      .output_enable_n_i(oe_n), .addr_i(addr), .data_i(wdata), .data_o, .data_oe_n_o,
      .asleep_o, .burst_addr_o);

   function automatic logic [DATA_W-1:0] pat(input logic [1:0] b);
      return {9{b, 2'h1}};
   endfunction
   task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // every start in both orders, stepped past the fourth address
   task automatic t_order;
      logic [1:0] e;
      for (int m = 0; m < 2; m++) begin
         for (int s = 0; s < 4; s++) begin
            @(negedge ref_clk_i);
            mode = m[0];
            host.cyc(m ? BEGIN_P : BEGIN_C, RD, 10'(s), '0);
            for (int j = 0; j < 6; j++) begin
               e = m ? 2'(s) ^ 2'(j) : 2'(s + j);
               chk("burst_addr", burst_addr_o, e);
               if (j < 5) host.cyc(CONT, RD, '0, '0);
            end
         end
      end
   endtask
   // write burst, byte write, ignored write, read back, deselect
   task automatic t_rw;
      logic [DATA_W-1:0] e;
      @(negedge ref_clk_i);
      mode = 1'b1;
      host.cyc(BEGIN_C, WR, 10'h042, pat(2'h2));
      for (int j = 1; j < 4; j++) host.cyc(CONT, WR, '0, pat(2'h2 ^ 2'(j)));
      host.cyc(BEGIN_C, BYTE0, 10'h043, '1);
      host.cyc(BEGIN_P, WR, 10'h041, '0);
      host.cyc(BEGIN_P, RD, 10'h040, '0);
      for (int j = 1; j < 5; j++) begin
         host.cyc(j < 4 ? CONT : DESEL, RD, '0, '0);
         e = pat(2'(j - 1));
         if (j == 4) e[8:0] = '1;
         chk("read_data", data_o, e);
         chk("drive", data_oe_n_o, 1'b0);
      end
      host.cyc(DESEL, RD, '0, '0);
      chk("drive", data_oe_n_o, 1'b1);
   endtask
   task automatic t_sleep;
      host.sleep_on();
      chk("sleep_drive", data_oe_n_o, 1'b1);
      host.cyc(5'b11111, RD, '0, '0);
      chk("asleep", asleep_o, 1'b1);
      host.sleep_off();
      chk("asleep", asleep_o, 1'b0);
      host.cyc(BEGIN_P, RD, 10'h042, '0);
      host.cyc(DESEL, RD, '0, '0);
      chk("retained", data_o, pat(2'h2));
   endtask

   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   // watchdog at about twenty times the expected run
   initial begin
      #(CLK_PERIOD_NS * 2000);
      n_mismatch++;
      stop_test();
   end
   initial begin
      rst_n_i = 1'b0;
      mode = 1'b1;
      repeat (12) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      t_order();
      t_rw();
      t_sleep();
      stop_test();
   end
endmodule
`default_nettype wire
